// *** logic/sys_ctrl_pkg.sv ***
package sys_ctrl_pkg;
	// Core data-memory bus, one request per cycle
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} dm_req_t;

	// Multiplexer and interrupt-enable lines steered by the mode control register
	typedef struct packed {
		logic [1:0] adc_mux_sel;
		logic       fault_int_en;
		logic       period_int_en;
		logic       uart_en;
		logic       rx_pin_sel;
	} mux_ctl_t;

	typedef enum logic [4:0] {
		BOOT_HOLD  = 5'h01,
		BOOT_PROBE = 5'h02,
		BOOT_LOAD  = 5'h04,
		BOOT_USER  = 5'h08,
		BOOT_DEBUG = 5'h10
	} boot_state_t;

	// Memory map
	localparam logic [13:0] PM_RAM_BASE     = 14'h0000;
	localparam logic [13:0] PM_ROM_BASE     = 14'h0800;
	localparam logic [13:0] PM_ROM_END      = 14'h0fff;
	localparam logic [15:0] PERIPH_BASE     = 16'h2000;
	localparam logic [15:0] PERIPH_END      = 16'h201f;
	localparam logic [15:0] DM_RAM_BASE     = 16'h3800;
	localparam logic [15:0] DM_USER_END     = 16'h3b8f;
	localparam logic [15:0] DM_MON_BASE     = 16'h3b90;
	localparam logic [15:0] DM_MON_END      = 16'h3bff;

	// Peripheral register indices inside the 32-word block
	localparam logic [4:0] IDX_PIO_INT_EN   = 5'h06;
	localparam logic [4:0] IDX_PIN_CHANGE   = 5'h07;
	localparam logic [4:0] IDX_MODE_CTRL    = 5'h15;
	localparam logic [4:0] IDX_SYS_STATUS   = 5'h16;
	localparam logic [4:0] IDX_PERIPH_INT   = 5'h17;

	// Mode control field positions
	localparam int MC_ADC_MUX_LSB = 0;
	localparam int MC_FAULT_EN    = 2;
	localparam int MC_PERIOD_EN   = 3;
	localparam int MC_UART_EN     = 4;
	localparam int MC_RX_SEL      = 5;
	localparam logic [5:0] MODE_CTRL_RST = 6'h00;

	// Peripheral interrupt status fields
	localparam int PI_FAULT  = 0;
	localparam int PI_PERIOD = 1;

	// Debug UART
	localparam int CLK_HZ    = 100_000_000;
	localparam int DEBUG_BAUD = 9600;
	localparam logic [15:0] DEBUG_BAUD_DIV = 16'(CLK_HZ / DEBUG_BAUD);
endpackage : sys_ctrl_pkg

// *** logic/sys_ctrl.sv ***
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - Reset after power-up leaves the clock running, no stabilisation wait.
// - Master reset masks all interrupts, clears mode status.
// - After reset release the core starts from internal ROM boot code.
// - Valid serial boot device on serial port one is loaded and run.
// - No valid boot device: debug mode, serial port one UART at 9600 baud.
// - Flag output two going 1, 0, 1 resets all peripherals and watchdog.
// - Program RAM decodes from 0x0000, program ROM from 0x800.
// - Data RAM decodes from 0x3800, peripheral block from 0x2000.
// - Data RAM user part 0x3800-0x3B8F, monitor part 0x3B90-0x3BFF.
// - Control registers are reached by data-memory reads and writes.
// - Global interrupt enable is set coming out of reset.
// - Enable instruction lets unmasked interrupts be serviced again.
// - Disable instruction blocks servicing, mask register untouched.
// - Autobuffer transfers proceed regardless of global enable.
// - Global disable also blocks the unmaskable power-down interrupt.
// - Data address decode gives a select strobe per peripheral register.
// - Drives ADC mux select and enables fault and period interrupts.
// - Drives serial-port multiplexer select lines.
// - Hardware, flag-toggle or watchdog reset clears peripheral registers bar the watchdog flag; core registers only on hardware reset.
// - Peripheral requests merge into one interrupt line to the core.
// - Combined line stays low until both status registers are read clear.
// - Registers are right-justified on 16 bits, unused upper bits read zero.
module sys_ctrl #(
	parameter int PIO_W = 8,
	parameter int INT_W = 10
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  reset_pin_n,
	input  wire logic                  flag_output_two,
	input  wire logic                  watchdog_reset,
	input  wire logic                  pwm_fault_input_n,
	input  wire logic                  pwm_period_pulse,
	input  wire logic [PIO_W-1:0]      pio_pins,
	input  wire sys_ctrl_pkg::dm_req_t dm_req,
	input  wire logic [13:0]           pm_addr,
	input  wire logic                  global_int_enable_instr,
	input  wire logic                  global_int_disable_instr,
	input  wire logic                  interrupt_mask_reg_wr,
	input  wire logic [INT_W-1:0]      interrupt_mask_reg_wdata,
	input  wire logic                  mode_status_reg_wr,
	input  wire logic [6:0]            mode_status_reg_wdata,
	input  wire logic [INT_W-1:0]      core_int_req,
	input  wire logic                  powerdown_req,
	input  wire logic                  autobuf_req,
	input  wire logic                  boot_probe_done,
	input  wire logic                  boot_dev_valid,
	input  wire logic                  boot_load_done,
	output logic [15:0]                rd_data_ff,
	output logic                       core_reset_ff,
	output logic                       periph_reset_ff,
	output logic [INT_W-1:0]           interrupt_mask_reg_ff,
	output logic [6:0]                 mode_status_reg_ff,
	output logic                       global_int_en_ff,
	output logic [INT_W-1:0]           int_service_ff,
	output logic                       powerdown_service_ff,
	output logic                       autobuf_go_ff,
	output logic                       run_from_rom_ff,
	output logic                       start_user_ff,
	output logic                       debug_uart_ff,
	output logic [15:0]                uart_baud_div_ff,
	output logic                       pm_ram_sel_ff,
	output logic                       pm_rom_sel_ff,
	output logic                       dm_user_sel_ff,
	output logic                       dm_monitor_sel_ff,
	output logic [31:0]                periph_sel_ff,
	output sys_ctrl_pkg::mux_ctl_t     mux_ctl_ff,
	output logic                       combined_peripheral_irq_n_ff
);
	// Refused at elaboration, before any logic is built on a bad width
	if (PIO_W < 1 || PIO_W > 16) begin : g_bad_pio_w
		$error("PIO_W must be 1..16");
	end
	if (INT_W < 1) begin : g_bad_int_w
		$error("INT_W must be positive");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
	localparam int SW = PIO_W + 2;
	logic [SW-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	logic [SW-1:0] pin_raw;
	assign pin_raw = {pio_pins, pwm_fault_input_n, reset_pin_n};

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_ff  <= '1;
			s2_ff  <= '1;
			s3_ff  <= '1;
			pin_ff <= '1;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < SW; i++) begin
				if (s2_ff[i] == s3_ff[i]) pin_ff[i] <= s3_ff[i];
			end
		end
	end

	logic             reset_lvl_n;
	logic             fault_lvl_n;
	logic [PIO_W-1:0] pio_lvl;
	assign reset_lvl_n = pin_ff[0];
	assign fault_lvl_n = pin_ff[1];
	assign pio_lvl     = pin_ff[SW-1:2];

	////////////////////////////////////////////////////////////////////////////
	// Reset generation; clock is never gated, so a later reset needs no wait
	logic flag_d_ff;
	logic flag_low_seen_ff;
	logic flag_seq;
	assign flag_seq = flag_low_seen_ff && flag_output_two;

	always_ff @(posedge clock) begin
		if (rst) begin
			core_reset_ff <= 1'b1;
		end else begin
			core_reset_ff <= ~reset_lvl_n;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || core_reset_ff) begin
			flag_d_ff        <= 1'b1;
			flag_low_seen_ff <= 1'b0;
		end else begin
			flag_d_ff <= flag_output_two;
			if (flag_seq) flag_low_seen_ff <= 1'b0;
			else if (flag_d_ff && !flag_output_two) flag_low_seen_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			periph_reset_ff <= 1'b1;
		end else begin
			periph_reset_ff <= core_reset_ff || flag_seq || watchdog_reset;
		end
	end

	logic pclr;
	assign pclr = rst || periph_reset_ff;

	////////////////////////////////////////////////////////////////////////////
	// Core-side state initialised by master reset: mask and mode status cleared, global enable set
	always_ff @(posedge clock) begin
		if (rst || core_reset_ff) begin
			interrupt_mask_reg_ff <= '0;
			mode_status_reg_ff    <= '0;
		end else begin
			if (interrupt_mask_reg_wr) interrupt_mask_reg_ff <= interrupt_mask_reg_wdata;
			if (mode_status_reg_wr) mode_status_reg_ff <= mode_status_reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || core_reset_ff) begin
			global_int_en_ff <= 1'b1;
		end else if (global_int_disable_instr) begin
			global_int_en_ff <= 1'b0;
		end else if (global_int_enable_instr) begin
			global_int_en_ff <= 1'b1;
		end
	end

	// Gating uses the current enable, so a disable takes effect one cycle later
	always_ff @(posedge clock) begin
		if (rst || core_reset_ff) begin
			int_service_ff       <= '0;
			powerdown_service_ff <= 1'b0;
			autobuf_go_ff        <= 1'b0;
		end else begin
			int_service_ff       <= core_int_req & interrupt_mask_reg_ff & {INT_W{global_int_en_ff}};
			powerdown_service_ff <= powerdown_req && global_int_en_ff;
			autobuf_go_ff        <= autobuf_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Boot sequencer
	sys_ctrl_pkg::boot_state_t boot_ff, nxt_boot;

	always_comb begin
		nxt_boot = boot_ff;
		case (boot_ff)
			sys_ctrl_pkg::BOOT_HOLD:  nxt_boot = sys_ctrl_pkg::BOOT_PROBE;
			sys_ctrl_pkg::BOOT_PROBE: begin
				if (boot_probe_done) begin
					nxt_boot = boot_dev_valid ? sys_ctrl_pkg::BOOT_LOAD : sys_ctrl_pkg::BOOT_DEBUG;
				end
			end
			sys_ctrl_pkg::BOOT_LOAD:  begin
				if (boot_load_done) nxt_boot = sys_ctrl_pkg::BOOT_USER;
			end
			sys_ctrl_pkg::BOOT_USER:  nxt_boot = sys_ctrl_pkg::BOOT_USER;
			sys_ctrl_pkg::BOOT_DEBUG: nxt_boot = sys_ctrl_pkg::BOOT_DEBUG;
			default:                  nxt_boot = sys_ctrl_pkg::BOOT_HOLD;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst || core_reset_ff) begin
			boot_ff          <= sys_ctrl_pkg::BOOT_HOLD;
			run_from_rom_ff  <= 1'b1;
			start_user_ff    <= 1'b0;
			debug_uart_ff    <= 1'b0;
			uart_baud_div_ff <= 16'h0000;
		end else begin
			boot_ff          <= nxt_boot;
			run_from_rom_ff  <= nxt_boot != sys_ctrl_pkg::BOOT_USER;
			start_user_ff    <= nxt_boot == sys_ctrl_pkg::BOOT_USER;
			debug_uart_ff    <= nxt_boot == sys_ctrl_pkg::BOOT_DEBUG;
			uart_baud_div_ff <= (nxt_boot == sys_ctrl_pkg::BOOT_DEBUG) ? sys_ctrl_pkg::DEBUG_BAUD_DIV : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory decode; selects are registered, one cycle behind the address
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	logic       is_periph;
	logic [4:0] pidx;
	assign is_periph = in_range(dm_req.addr, sys_ctrl_pkg::PERIPH_BASE, sys_ctrl_pkg::PERIPH_END);
	assign pidx      = dm_req.addr[4:0];

	always_ff @(posedge clock) begin
		if (rst) begin
			pm_ram_sel_ff     <= 1'b0;
			pm_rom_sel_ff     <= 1'b0;
			dm_user_sel_ff    <= 1'b0;
			dm_monitor_sel_ff <= 1'b0;
			periph_sel_ff     <= '0;
		end else begin
			pm_ram_sel_ff     <= pm_addr < sys_ctrl_pkg::PM_ROM_BASE;
			pm_rom_sel_ff     <= in_range({2'b00, pm_addr}, {2'b00, sys_ctrl_pkg::PM_ROM_BASE},
				{2'b00, sys_ctrl_pkg::PM_ROM_END});
			dm_user_sel_ff    <= in_range(dm_req.addr, sys_ctrl_pkg::DM_RAM_BASE, sys_ctrl_pkg::DM_USER_END);
			dm_monitor_sel_ff <= in_range(dm_req.addr, sys_ctrl_pkg::DM_MON_BASE, sys_ctrl_pkg::DM_MON_END);
			periph_sel_ff     <= (is_periph && (dm_req.wr || dm_req.rd)) ? 32'h1 << pidx : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Peripheral registers held here
	logic       wr_hit, rd_hit;
	assign wr_hit = dm_req.wr && is_periph;
	assign rd_hit = dm_req.rd && is_periph;

	logic [PIO_W-1:0] pio_int_en_ff, pin_change_ff, pio_prev_ff;
	logic [1:0]       periph_int_ff;
	logic             fault_prev_ff, period_prev_ff, wdog_flag_ff;
	logic             fault_evt, period_evt;
	logic [PIO_W-1:0] pio_evt;
	assign fault_evt  = fault_prev_ff && !fault_lvl_n;
	assign period_evt = !period_prev_ff && pwm_period_pulse;
	assign pio_evt    = (pio_lvl ^ pio_prev_ff) & pio_int_en_ff;

	always_ff @(posedge clock) begin
		if (pclr) begin
			mux_ctl_ff    <= sys_ctrl_pkg::MODE_CTRL_RST;
			pio_int_en_ff <= '0;
		end else if (wr_hit && pidx == sys_ctrl_pkg::IDX_MODE_CTRL) begin
			mux_ctl_ff.adc_mux_sel   <= dm_req.wdata[sys_ctrl_pkg::MC_ADC_MUX_LSB +: 2];
			mux_ctl_ff.fault_int_en  <= dm_req.wdata[sys_ctrl_pkg::MC_FAULT_EN];
			mux_ctl_ff.period_int_en <= dm_req.wdata[sys_ctrl_pkg::MC_PERIOD_EN];
			mux_ctl_ff.uart_en       <= dm_req.wdata[sys_ctrl_pkg::MC_UART_EN];
			mux_ctl_ff.rx_pin_sel    <= dm_req.wdata[sys_ctrl_pkg::MC_RX_SEL];
		end else if (wr_hit && pidx == sys_ctrl_pkg::IDX_PIO_INT_EN) begin
			pio_int_en_ff <= dm_req.wdata[PIO_W-1:0];
		end
	end

	// Status flags: a new event beats a clearing read in the same cycle
	always_ff @(posedge clock) begin
		if (pclr) begin
			periph_int_ff  <= 2'b00;
			pin_change_ff  <= '0;
			fault_prev_ff  <= 1'b1;
			period_prev_ff <= 1'b0;
			pio_prev_ff    <= pio_lvl;
		end else begin
			fault_prev_ff  <= fault_lvl_n;
			period_prev_ff <= pwm_period_pulse;
			pio_prev_ff    <= pio_lvl;
			periph_int_ff[sys_ctrl_pkg::PI_FAULT] <= fault_evt ||
				(periph_int_ff[sys_ctrl_pkg::PI_FAULT] && !(rd_hit && pidx == sys_ctrl_pkg::IDX_PERIPH_INT));
			periph_int_ff[sys_ctrl_pkg::PI_PERIOD] <= period_evt ||
				(periph_int_ff[sys_ctrl_pkg::PI_PERIOD] && !(rd_hit && pidx == sys_ctrl_pkg::IDX_PERIPH_INT));
			pin_change_ff <= pio_evt |
				(pin_change_ff & {PIO_W{!(rd_hit && pidx == sys_ctrl_pkg::IDX_PIN_CHANGE)}});
		end
	end

	// Watchdog flag survives core and peripheral resets; only rst clears it
	always_ff @(posedge clock) begin
		if (rst) wdog_flag_ff <= 1'b0;
		else if (watchdog_reset) wdog_flag_ff <= 1'b1;
	end

	// Fault and period enables mask the line only; their flags are still recorded
	always_ff @(posedge clock) begin
		if (pclr) begin
			combined_peripheral_irq_n_ff <= 1'b1;
		end else begin
			combined_peripheral_irq_n_ff <= !((periph_int_ff[sys_ctrl_pkg::PI_FAULT] && mux_ctl_ff.fault_int_en) ||
				(periph_int_ff[sys_ctrl_pkg::PI_PERIOD] && mux_ctl_ff.period_int_en) ||
				(|pin_change_ff));
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data_ff <= 16'h0000;
		end else if (rd_hit) begin
			case (pidx)
				sys_ctrl_pkg::IDX_MODE_CTRL:  rd_data_ff <= {10'h000, mux_ctl_ff.rx_pin_sel, mux_ctl_ff.uart_en,
					mux_ctl_ff.period_int_en, mux_ctl_ff.fault_int_en, mux_ctl_ff.adc_mux_sel};
				sys_ctrl_pkg::IDX_SYS_STATUS: rd_data_ff <= {14'h0000, wdog_flag_ff, fault_lvl_n};
				sys_ctrl_pkg::IDX_PERIPH_INT: rd_data_ff <= {14'h0000, periph_int_ff};
				sys_ctrl_pkg::IDX_PIO_INT_EN: rd_data_ff <= 16'(pio_int_en_ff);
				sys_ctrl_pkg::IDX_PIN_CHANGE: rd_data_ff <= 16'(pin_change_ff);
				default:                      rd_data_ff <= 16'h0000;
			endcase
		end else begin
			rd_data_ff <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_GIE_RESET: assert property (@(posedge clock) disable iff (rst)
		$fell(core_reset_ff) |-> global_int_en_ff) else $error("enable not set after reset");
	AST_DIS_BLOCKS: assert property (@(posedge clock) disable iff (rst)
		(!global_int_en_ff && !core_reset_ff) |=> (int_service_ff == '0 && !powerdown_service_ff))
		else $error("service while disabled");
	AST_PD_BLOCK: assert property (@(posedge clock) disable iff (rst)
		(powerdown_req && !global_int_en_ff) |=> !powerdown_service_ff) else $error("power-down not blocked");
	AST_MASK_KEPT: assert property (@(posedge clock) disable iff (rst)
		(global_int_disable_instr && !interrupt_mask_reg_wr && !core_reset_ff) |=> $stable(interrupt_mask_reg_ff))
		else $error("mask changed by disable");
	AST_AUTOBUF: assert property (@(posedge clock) disable iff (rst || core_reset_ff)
		autobuf_req |=> autobuf_go_ff) else $error("autobuffer blocked");
	AST_MASTER_CLR: assert property (@(posedge clock) disable iff (rst)
		core_reset_ff |=> (interrupt_mask_reg_ff == '0 && mode_status_reg_ff == '0)) else $error("reset not cleared");
	// Shortest legal toggle: one low cycle between two high ones
	AST_FLAG_SEQ: assert property (@(posedge clock) disable iff (rst || core_reset_ff)
		(flag_d_ff && !flag_output_two) ##1 flag_output_two |=> periph_reset_ff)
		else $error("flag toggle missed");
	AST_PRST_CLR: assert property (@(posedge clock) disable iff (rst)
		periph_reset_ff |=> (mux_ctl_ff == '0 && pin_change_ff == '0 && periph_int_ff == 2'b00))
		else $error("peripheral not cleared");
	AST_IRQ_HOLD: assert property (@(posedge clock) disable iff (pclr)
		(|pin_change_ff) |=> !combined_peripheral_irq_n_ff) else $error("irq released early");
	AST_DEBUG_FALL: assert property (@(posedge clock) disable iff (rst || core_reset_ff)
		(boot_ff == sys_ctrl_pkg::BOOT_PROBE && boot_probe_done && !boot_dev_valid) |=> ##1
		(debug_uart_ff && uart_baud_div_ff == sys_ctrl_pkg::DEBUG_BAUD_DIV)) else $error("no debug fallback");
	AST_PERIPH_SEL: assert property (@(posedge clock) disable iff (rst)
		(dm_req.rd && dm_req.addr == 16'h2015) |=> periph_sel_ff == 32'h0020_0000) else $error("bad select");
	AST_ROM_DEC: assert property (@(posedge clock) disable iff (rst)
		(pm_addr == 14'h0800) |=> (pm_rom_sel_ff && !pm_ram_sel_ff)) else $error("rom decode");

	CVR_FLAG_RESET: cover property (@(posedge clock) disable iff (rst) flag_seq);
	CVR_USER_BOOT:  cover property (@(posedge clock) disable iff (rst) start_user_ff);
	CVR_IRQ_CLEAR:  cover property (@(posedge clock) disable iff (rst) $rose(combined_peripheral_irq_n_ff));
	CVR_DISABLE:    cover property (@(posedge clock) disable iff (rst) $fell(global_int_en_ff));
endmodule : sys_ctrl

// *** sim/core_model.sv ***
`timescale 1ns/1ns
module core_model #(
	parameter int PROBE_CYC = 6,
	parameter int LOAD_CYC  = 20
) (
	input  wire logic clock,
	input  wire logic core_reset,
	input  wire logic dev_present,
	output logic      probe_done,
	output logic      dev_valid,
	output logic      load_done
);
	logic [7:0] cnt_ff;

	// Boot code restarts on every master reset
	always_ff @(posedge clock) begin
		if (core_reset) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff != 8'hff) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Validity line only means something while the probe reports, so it lies otherwise
	assign probe_done = (cnt_ff == 8'(PROBE_CYC));
	assign dev_valid  = probe_done ? dev_present : ~dev_present;
	assign load_done  = dev_present && (cnt_ff == 8'(LOAD_CYC));
endmodule : core_model

// *** sim/dsp_reset_and_system_control_tb.sv ***
`timescale 1ns/1ns
module dsp_reset_and_system_control_tb;
	logic clock, rst, reset_pin_n, flag_output_two, watchdog_reset, pwm_fault_input_n, pwm_period_pulse;
	logic [7:0] pio_pins;
	sys_ctrl_pkg::dm_req_t dm_req;
	logic [13:0] pm_addr;
	logic global_int_enable_instr, global_int_disable_instr, interrupt_mask_reg_wr, mode_status_reg_wr, powerdown_req, autobuf_req;
	logic [9:0] interrupt_mask_reg_wdata, core_int_req, interrupt_mask_reg_ff, int_service_ff;
	logic [6:0] mode_status_reg_wdata, mode_status_reg_ff;
	logic boot_probe_done, boot_dev_valid, boot_load_done, dev_present;
	logic [15:0] rd_data_ff, uart_baud_div_ff, d;
	logic core_reset_ff, periph_reset_ff, global_int_en_ff, powerdown_service_ff, autobuf_go_ff, run_from_rom_ff;
	logic start_user_ff, debug_uart_ff, pm_ram_sel_ff, pm_rom_sel_ff, dm_user_sel_ff, dm_monitor_sel_ff;
	logic combined_peripheral_irq_n_ff;
	logic [31:0] periph_sel_ff;
	sys_ctrl_pkg::mux_ctl_t mux_ctl_ff;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [13:0] pa [4] = '{14'h0000, 14'h07ff, 14'h0800, 14'h0fff};
	logic [1:0]  pe [4] = '{2'b10, 2'b10, 2'b01, 2'b01};
	logic [15:0] da [8] = '{16'h3800, 16'h3b8f, 16'h3b90, 16'h3bff, 16'h2000, 16'h2015, 16'h201f, 16'h2020};
	logic [1:0]  de [8] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b00, 2'b00, 2'b00, 2'b00};
	logic [31:0] ps [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0020_0000, 32'h8000_0000, 32'h0};

	sys_ctrl DUT (.clock, .rst, .reset_pin_n, .flag_output_two, .watchdog_reset, .pwm_fault_input_n,
		.pwm_period_pulse, .pio_pins, .dm_req, .pm_addr, .global_int_enable_instr, .global_int_disable_instr,
		.interrupt_mask_reg_wr, .interrupt_mask_reg_wdata, .mode_status_reg_wr, .mode_status_reg_wdata, .core_int_req, .powerdown_req, .autobuf_req,
		.boot_probe_done, .boot_dev_valid, .boot_load_done, .rd_data_ff, .core_reset_ff, .periph_reset_ff,
		.interrupt_mask_reg_ff, .mode_status_reg_ff, .global_int_en_ff, .int_service_ff, .powerdown_service_ff,
		.autobuf_go_ff, .run_from_rom_ff, .start_user_ff, .debug_uart_ff, .uart_baud_div_ff, .pm_ram_sel_ff,
		.pm_rom_sel_ff, .dm_user_sel_ff, .dm_monitor_sel_ff, .periph_sel_ff, .mux_ctl_ff,
		.combined_peripheral_irq_n_ff);

	core_model partner (.clock(clock), .core_reset(core_reset_ff), .dev_present(dev_present),
		.probe_done(boot_probe_done), .dev_valid(boot_dev_valid), .load_done(boot_load_done));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic bus_wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clock);
		dm_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		dm_req <= '0;
	endtask : bus_wr

	// Read data only stand in the cycle after the strobe
	task automatic bus_rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clock);
		dm_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		dm_req <= '0;
		#1 v = rd_data_ff;
	endtask : bus_rd

	task automatic wait_boot;
		for (int i = 0; i < 300; i++) begin
			@(posedge clock);
			#1;
			if (debug_uart_ff === 1'b1 || start_user_ff === 1'b1) break;
		end
	endtask : wait_boot

	// Pulse is one cycle long and may already stand at the call, so look before each edge
	task automatic wait_prst;
		logic got;
		got = 1'b0;
		for (int i = 0; i < 8; i++) begin
			#1;
			if (periph_reset_ff === 1'b1) got = 1'b1;
			@(posedge clock);
		end
		check("periph_reset", got, 1);
	endtask : wait_prst

	task automatic edges(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : edges

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		{rst, reset_pin_n, flag_output_two, pwm_fault_input_n} = 4'hf;
		{watchdog_reset, pwm_period_pulse, global_int_enable_instr, global_int_disable_instr} = 4'h0;
		{interrupt_mask_reg_wr, mode_status_reg_wr, powerdown_req, autobuf_req, dev_present} = 5'h00;
		{pio_pins, pm_addr, interrupt_mask_reg_wdata, mode_status_reg_wdata, core_int_req} = '0;
		dm_req = '0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		#1 check("global_en", global_int_en_ff, 1);
		check("run_rom", run_from_rom_ff, 1);
		check("irq_n", combined_peripheral_irq_n_ff, 1);
		@(posedge clock) reset_pin_n <= 1'b0;
		edges(2000);
		check("core_reset", core_reset_ff, 1);
		@(posedge clock) reset_pin_n <= 1'b1;
		wait_boot();
		check("debug", {start_user_ff, debug_uart_ff}, 2'b01);
		check("baud", uart_baud_div_ff, 16'(100_000_000 / 9600));
		$display("test power_up done");
		@(posedge clock) {mode_status_reg_wr, interrupt_mask_reg_wr, mode_status_reg_wdata, interrupt_mask_reg_wdata} <= {2'b11, 7'h7f, 10'h3ff};
		@(posedge clock) {mode_status_reg_wr, interrupt_mask_reg_wr} <= 2'b00;
		@(posedge clock) global_int_disable_instr <= 1'b1;
		@(posedge clock) global_int_disable_instr <= 1'b0;
		@(posedge clock) {dev_present, reset_pin_n} <= 2'b10;
		edges(8);
		check("core_reset", core_reset_ff, 1);
		check("cleared", {interrupt_mask_reg_ff, mode_status_reg_ff}, 17'h0);
		check("global_en", global_int_en_ff, 1);
		@(posedge clock) reset_pin_n <= 1'b1;
		wait_boot();
		check("user", {start_user_ff, debug_uart_ff}, 2'b10);
		check("run_rom", run_from_rom_ff, 0);
		$display("test warm_reset done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) pm_addr <= pa[i];
			edges(1);
			check("pm_sel", {pm_ram_sel_ff, pm_rom_sel_ff}, pe[i]);
		end
		for (int i = 0; i < 8; i++) begin
			bus_rd(da[i], d);
			check("dm_sel", {dm_user_sel_ff, dm_monitor_sel_ff}, de[i]);
			check("periph_sel", periph_sel_ff, ps[i]);
		end
		check("unmapped", d, 16'h0000);
		$display("test decode done");
		bus_wr(16'h2015, 16'hffff);
		bus_rd(16'h2015, d);
		check("mode_ctrl", d, 16'h003f);
		bus_wr(16'h2015, 16'h0021);
		bus_rd(16'h2015, d);
		check("mux", mux_ctl_ff, 6'b010001);
		$display("test mode_ctrl done");
		bus_wr(16'h2015, 16'h000c);
		bus_wr(16'h2006, 16'h0001);
		@(posedge clock) {pwm_period_pulse, pio_pins, pwm_fault_input_n} <= {1'b1, 8'h01, 1'b0};
		@(posedge clock) pwm_period_pulse <= 1'b0;
		edges(8);
		check("irq_n", combined_peripheral_irq_n_ff, 0);
		bus_rd(16'h2016, d);
		check("status", d, 16'h0000);
		bus_rd(16'h2017, d);
		check("irq_flags", d, 16'h0003);
		@(posedge clock) pwm_fault_input_n <= 1'b1;
		edges(3);
		check("irq_n", combined_peripheral_irq_n_ff, 0);
		bus_rd(16'h2007, d);
		check("pin_flags", d, 16'h0001);
		edges(2);
		check("irq_n", combined_peripheral_irq_n_ff, 1);
		$display("test interrupts done");
		@(posedge clock) {interrupt_mask_reg_wr, interrupt_mask_reg_wdata, core_int_req, powerdown_req, autobuf_req} <= {1'b1, 10'h3f0, 10'h0ff, 2'b11};
		@(posedge clock) interrupt_mask_reg_wr <= 1'b0;
		edges(2);
		check("service", {int_service_ff, powerdown_service_ff}, {10'h0f0, 1'b1});
		@(posedge clock) global_int_disable_instr <= 1'b1;
		@(posedge clock) global_int_disable_instr <= 1'b0;
		edges(2);
		check("service", {int_service_ff, interrupt_mask_reg_ff}, {10'h000, 10'h3f0});
		check("powerdown", powerdown_service_ff, 0);
		check("autobuf", autobuf_go_ff, 1);
		@(posedge clock) global_int_enable_instr <= 1'b1;
		@(posedge clock) global_int_enable_instr <= 1'b0;
		edges(2);
		check("service", int_service_ff, 10'h0f0);
		$display("test global_int done");
		bus_wr(16'h2015, 16'h003f);
		@(posedge clock) flag_output_two <= 1'b0;
		@(posedge clock) flag_output_two <= 1'b1;
		wait_prst();
		bus_rd(16'h2015, d);
		check("mode_ctrl", d, 16'h0000);
		bus_wr(16'h2015, 16'h003f);
		@(posedge clock) watchdog_reset <= 1'b1;
		@(posedge clock) watchdog_reset <= 1'b0;
		wait_prst();
		bus_rd(16'h2015, d);
		check("mode_ctrl", d, 16'h0000);
		bus_rd(16'h2016, d);
		check("status", d, 16'h0003);
		$display("test periph_reset done");
		close_out();
	end
endmodule : dsp_reset_and_system_control_tb
